// ===== design/wd_pkg.sv
package wd_pkg;
  localparam logic [7:0] CTRL_ADDR       = 8'h2a;
  localparam logic [7:0] CTRL_RESET      = 8'h7f;
  localparam int         ARM_BIT         = 7;
  localparam int         TOP_BIT         = 6;
  localparam logic [6:0] EXPIRE_COUNT    = 7'h40;
  localparam int         PRESCALE_CYCLES = 16384;
  localparam int         PRESCALE_W      = 14;
  localparam int         RST_PULSE_NS    = 30000;
  localparam int         CLK_PERIOD_NS   = 5;
  localparam int         RST_PULSE_CYC   =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         PULSE_W         = 13;
  localparam int         START_SHORT     = 256;
  localparam int         START_LONG      = 4096;
  localparam int         START_W         = 13;
endpackage

// ===== design/halt_aware_watchdog.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
// Function
// - slow and wait modes do not affect counting or reset ability
// - halt with irq enable and halt option clear: one decrement, then stop
// - after such halt, an external interrupt resumes counting
// - after reset the watchdog is disarmed unless hardware option set
// - halt with irq enable clear and halt option set gives a reset
// - halt with irq enable set: active halt, counter frozen, no reset
// - leaving active halt by interrupt resumes counting at once
// - leaving active halt by reset resumes after 256 or 4096 clocks
// - hardware option: always active, arm bit has no effect
// - control register: bit 7 arm, bits 6:0 counter, read/write
// - only a write sets arm, only reset clears it
// - reset generation allowed only when armed or hardware option, except the halt option reset, which fires while disarmed
// - counter decrements every 16384 oscillator cycles
// - armed reset when counter bit 6 becomes zero
// - counter keeps decrementing while disarmed
// - watchdog reset holds the reset request for about 30 us
// - write arming with bit 6 clear gives immediate reset
module halt_aware_watchdog (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  output logic      [7:0] rdata_out,
  input  wire logic       halt_reset_option_in,
  input  wire logic       hw_watchdog_option_in,
  input  wire logic       timebase_irq_enable_in,
  input  wire logic       halt_req_in,
  input  wire logic       ext_wake_in,
  input  wire logic       timebase_wake_in,
  input  wire logic       startup_long_in,
  output logic            reset_req_out,
  output logic            halted_out
);
  // -------------------------------------------------------------------
  // mode state
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    RUN_S    = 2'b00,
    HALT_S   = 2'b01,
    AHALT_S  = 2'b10,
    START_S  = 2'b11
  } mode_t;

  mode_t                   mode_reg;
  logic                    arm_reg;
  logic [6:0]              count_reg;
  logic [wd_pkg::PRESCALE_W-1:0] pre_reg;
  logic                    halt_dec_done_reg;
  logic [wd_pkg::PULSE_W-1:0]    pulse_reg;
  logic [wd_pkg::START_W-1:0]    start_reg;
  logic                    ahalt_reset_pend_reg;
  logic                    tick;
  logic                    ctrl_wr;
  logic                    active;
  logic                    counting;
  logic                    fire;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == wd_pkg::CTRL_ADDR);
  endfunction

  assign ctrl_wr  = wr_in && hit(addr_in);
  assign active   = arm_reg || hw_watchdog_option_in;
  assign tick     = (pre_reg == wd_pkg::PRESCALE_W'(
                     wd_pkg::PRESCALE_CYCLES - 1));
  // slow and wait are not seen here: counting ignores them
  assign counting = (mode_reg == RUN_S) ||
                    (mode_reg == HALT_S && !halt_dec_done_reg);

  // -------------------------------------------------------------------
  // prescaler
  // -------------------------------------------------------------------
  // phase never reset by writes, so software cannot know it
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pre_reg <= '0;
    end else if (counting) begin
      pre_reg <= tick ? '0 : pre_reg + 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // control register
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      arm_reg <= wd_pkg::CTRL_RESET[wd_pkg::ARM_BIT];
    end else if (ctrl_wr && wdata_in[wd_pkg::ARM_BIT]) begin
      arm_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= wd_pkg::CTRL_RESET[6:0];
    end else if (ctrl_wr) begin
      count_reg <= wdata_in[6:0];
    end else if (counting && tick) begin
      count_reg <= count_reg - 7'h01;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in && hit(addr_in)) begin
      rdata_out <= {arm_reg, count_reg};
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // -------------------------------------------------------------------
  // halt handling
  // -------------------------------------------------------------------
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_reg          <= RUN_S;
      halt_dec_done_reg <= 1'b0;
      start_reg         <= '0;
    end else begin
      case (mode_reg)
        RUN_S: begin
          halt_dec_done_reg <= 1'b0;
          if (halt_req_in && !fire && !pulse_reg_busy()) begin
            if (timebase_irq_enable_in) begin
              mode_reg <= AHALT_S;
            end else if (!halt_reset_option_in) begin
              mode_reg <= HALT_S;
            end
          end
        end
        HALT_S: begin
          if (counting && tick) begin
            halt_dec_done_reg <= 1'b1;
          end
          if (ext_wake_in) begin
            mode_reg <= RUN_S;
          end
        end
        AHALT_S: begin
          if (ext_wake_in || timebase_wake_in) begin
            mode_reg <= RUN_S;
          end else if (ahalt_reset_pend_reg) begin
            mode_reg  <= START_S;
            start_reg <= startup_long_in ?
              wd_pkg::START_W'(wd_pkg::START_LONG - 1) :
              wd_pkg::START_W'(wd_pkg::START_SHORT - 1);
          end
        end
        START_S: begin
          if (start_reg == '0) begin
            mode_reg <= RUN_S;
          end else begin
            start_reg <= start_reg - 1'b1;
          end
        end
        default: mode_reg <= RUN_S;
      endcase
    end
  end

  function automatic logic pulse_reg_busy();
    pulse_reg_busy = (pulse_reg != '0);
  endfunction

  // a reset met in active halt is our own request seen in that mode;
  // it leads through the startup delay state before counting resumes
  // limitation: resets from other sources are not visible to this block
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ahalt_reset_pend_reg <= 1'b0;
    end else begin
      ahalt_reset_pend_reg <= (mode_reg == AHALT_S) && reset_req_out;
    end
  end

  // -------------------------------------------------------------------
  // reset generation
  // -------------------------------------------------------------------
  always_comb begin
    fire = 1'b0;
    if (ctrl_wr && (wdata_in[wd_pkg::ARM_BIT] || active) &&
        !wdata_in[wd_pkg::TOP_BIT]) begin
      fire = 1'b1;
    end else if (active && counting && tick && !ctrl_wr &&
                 count_reg == wd_pkg::EXPIRE_COUNT) begin
      fire = 1'b1;
    end else if (mode_reg == RUN_S && halt_req_in &&
                 !timebase_irq_enable_in && halt_reset_option_in) begin
      fire = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pulse_reg     <= '0;
      reset_req_out <= 1'b0;
    end else if (fire && pulse_reg == '0) begin
      pulse_reg     <= wd_pkg::PULSE_W'(wd_pkg::RST_PULSE_CYC - 1);
      reset_req_out <= 1'b1;
    end else if (pulse_reg != '0) begin
      pulse_reg     <= pulse_reg - 1'b1;
      reset_req_out <= 1'b1;
    end else begin
      reset_req_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      halted_out <= 1'b0;
    end else begin
      halted_out <= (mode_reg == HALT_S) || (mode_reg == AHALT_S);
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  // startup delay is too long for a repetition, so a counter measures it
  logic [wd_pkg::START_W-1:0] start_seen_reg;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_seen_reg <= '0;
    end else if (mode_reg == START_S) begin
      start_seen_reg <= start_seen_reg + 1'b1;
    end else begin
      start_seen_reg <= '0;
    end
  end

  arm_sticky_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $past(arm_reg) |-> arm_reg)
    else $error("arm cleared");
  arm_set_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ctrl_wr && wdata_in[wd_pkg::ARM_BIT] |=> arm_reg)
    else $error("arm not set");
  ahalt_freeze_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == AHALT_S && !ctrl_wr |=> $stable(count_reg))
    else $error("count moved in active halt");
  sw_reset_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ctrl_wr && wdata_in[wd_pkg::ARM_BIT] && !wdata_in[wd_pkg::TOP_BIT] &&
    !reset_req_out |=> reset_req_out)
    else $error("no software reset");
  halt_opt_rst_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == RUN_S && halt_req_in && !timebase_irq_enable_in &&
    halt_reset_option_in
    |=> reset_req_out && mode_reg == RUN_S)
    else $error("halt option reset missing");
  pulse_len_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    $rose(reset_req_out) |-> reset_req_out [*8])
    else $error("reset pulse too short");
  disarm_quiet_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !active && !ctrl_wr && !halt_req_in && pulse_reg == '0
    |=> !reset_req_out)
    else $error("reset while disarmed");
  expire_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    active && counting && tick && !ctrl_wr &&
    count_reg == wd_pkg::EXPIRE_COUNT && pulse_reg == '0
    |=> reset_req_out && count_reg == wd_pkg::EXPIRE_COUNT - 7'h01)
    else $error("expiry reset missing");
  halt_once_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == HALT_S && halt_dec_done_reg && !ctrl_wr |=> $stable(count_reg))
    else $error("count after halt step");
  wake_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == AHALT_S && ext_wake_in |=> mode_reg == RUN_S)
    else $error("no wake from active halt");
  halt_wake_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == HALT_S && ext_wake_in |=> mode_reg == RUN_S)
    else $error("no wake from halt");
  halt_enter_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == RUN_S && halt_req_in && !fire && pulse_reg == '0 &&
    !timebase_irq_enable_in && !halt_reset_option_in
    |=> mode_reg == HALT_S)
    else $error("halt not entered");
  ahalt_enter_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == RUN_S && halt_req_in && !fire && pulse_reg == '0 &&
    timebase_irq_enable_in
    |=> mode_reg == AHALT_S && !reset_req_out)
    else $error("active halt not entered");
  start_len_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == START_S && start_reg == '0
    |-> start_seen_reg == (startup_long_in ?
        wd_pkg::START_W'(wd_pkg::START_LONG - 1) :
        wd_pkg::START_W'(wd_pkg::START_SHORT - 1)))
    else $error("startup delay length wrong");
  start_freeze_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == START_S && !ctrl_wr |=> $stable(count_reg))
    else $error("count moved during startup");
  ctrl_read_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    rd_in && hit(addr_in) |=> rdata_out == $past({arm_reg, count_reg}))
    else $error("read data wrong");
  rdata_idle_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !(rd_in && hit(addr_in)) |=> rdata_out == 8'h00)
    else $error("read data not idle");
  count_load_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    ctrl_wr |=> count_reg == $past(wdata_in[6:0]))
    else $error("count not loaded");
  free_run_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == RUN_S && tick && !ctrl_wr
    |=> count_reg == $past(count_reg) - 7'h01)
    else $error("count did not step");
  pre_hold_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    !counting |=> $stable(pre_reg))
    else $error("prescaler ran while stopped");
  hw_expire_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    hw_watchdog_option_in && counting && tick && !ctrl_wr &&
    count_reg == wd_pkg::EXPIRE_COUNT && pulse_reg == '0
    |=> reset_req_out)
    else $error("hardware option expiry missing");
  req_pulse_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    fire && !reset_req_out |=> reset_req_out)
    else $error("reset request not raised");
  halted_flag_a: assert property (
    @(posedge clk_in) disable iff (!resetn_in)
    mode_reg == HALT_S || mode_reg == AHALT_S |=> halted_out)
    else $error("halted flag missing");
endmodule // halt_aware_watchdog

// ===== test/cpu_model.sv
`timescale 1ns/1ps
// --------------------------
// core software side
// --------------------------
module cpu_model (
  input  wire logic       clk_in,
  input  wire logic [7:0] rdata_in,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  output logic            wr_out,
  output logic            rd_out,
  output logic            halt_out,
  output logic            wake_out
);
  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    halt_out = 1'b0;
    wake_out = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge clk_in);
    wr_out <= 1'b0;
    wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge clk_in);
    rd_out <= 1'b0;
    #1 d = rdata_in;
  endtask
  // strobe held high so each cycle shows the live count
  task automatic ticks(output logic [7:0] v1, output logic [7:0] v2,
                       output int gap);
    logic [7:0] old;
    int         n;
    @(posedge clk_in);
    addr_out <= wd_pkg::CTRL_ADDR;
    rd_out <= 1'b1;
    @(posedge clk_in);
    #1 old = rdata_in;
    v1 = old;
    n = 0;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while (rdata_in === old && n < 20000) begin
        @(posedge clk_in);
        #1 n = n + 1;
      end
      old = rdata_in;
      if (k == 0) v1 = old;
    end
    v2 = old;
    gap = n;
    @(posedge clk_in);
    rd_out <= 1'b0;
  endtask
  // reload first so a wake does not meet a nearly expired count
  task automatic halt(input logic [7:0] reload);
    wr(wd_pkg::CTRL_ADDR, reload);
    @(posedge clk_in);
    halt_out <= 1'b1;
    @(posedge clk_in);
    halt_out <= 1'b0;
  endtask
  task automatic wake();
    @(posedge clk_in);
    wake_out <= 1'b1;
    @(posedge clk_in);
    wake_out <= 1'b0;
  endtask
endmodule // cpu_model

// ===== test/tb_halt_aware_watchdog.sv
`timescale 1ns/1ps
module tb_halt_aware_watchdog;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d;} row_t;
  logic       clk = 1'b0;
  logic       resetn = 1'b0;
  logic       halt_opt = 1'b0;
  logic       hw_opt = 1'b0;
  logic       irq_en = 1'b0;
  logic       ext_wake = 1'b0;
  logic       long_start = 1'b0;
  logic [7:0] addr, wdata, rdata, v1, v2;
  logic       wr, rd, halt, wake, reset_req, halted;
  int         n_mismatch = 0;
  int         tests_run = 0;
  int         gap, n;
  row_t       rows [9] = '{'{0, 8'h2a, 8'h7f}, '{0, 8'h00, 8'h00},
    '{1, 8'h2a, 8'h15}, '{0, 8'h2a, 8'h15}, '{1, 8'h2b, 8'h80},
    '{0, 8'h2a, 8'h15}, '{0, 8'h2b, 8'h00}, '{1, 8'h2a, 8'h7f},
    '{0, 8'h2a, 8'h7f}};
  halt_aware_watchdog halt_aware_watchdog_inst (.clk_in(clk),
    .resetn_in(resetn), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .halt_reset_option_in(halt_opt),
    .hw_watchdog_option_in(hw_opt), .timebase_irq_enable_in(irq_en),
    .halt_req_in(halt), .ext_wake_in(ext_wake), .timebase_wake_in(wake),
    .startup_long_in(long_start), .reset_req_out(reset_req),
    .halted_out(halted));
  cpu_model cpu_model_inst (.clk_in(clk), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd),
    .halt_out(halt), .wake_out(wake));
  // --------------------------
  // helpers
  // --------------------------
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
  endtask
  task automatic wait_req(input int lim);
    n = 0;
    while (reset_req !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (99000) @(posedge clk);
    n_mismatch++;
    give_verdict();
  end
  // --------------------------
  // main sequence
  // --------------------------
  initial begin
    do_reset();
    foreach (rows[i]) begin
      if (rows[i].w) cpu_model_inst.wr(rows[i].a, rows[i].d);
      else begin
        cpu_model_inst.rd(rows[i].a, v1);
        check("table read", v1, rows[i].d);
      end
    end
    check("disarmed reset", reset_req, 1'b0);
    cpu_model_inst.ticks(v1, v2, gap);
    check("first tick", v1, 8'h7e);
    check("second tick", v2, 8'h7d);
    check("tick period", gap, wd_pkg::PRESCALE_CYCLES);
    cpu_model_inst.wr(8'h2a, 8'h80);
    #1 check("software reset", reset_req, 1'b1);
    n = 0;
    while (reset_req === 1'b1 && n < 7000) begin
      @(posedge clk);
      #1 n++;
    end
    check("pulse length", n, wd_pkg::RST_PULSE_CYC);
    cpu_model_inst.wr(8'h2a, 8'h40);
    cpu_model_inst.rd(8'h2a, v1);
    check("arm kept", v1, 8'hc0);
    wait_req(17000);
    check("rollover reset", reset_req, 1'b1);
    do_reset();
    cpu_model_inst.rd(8'h2a, v1);
    check("disarmed after reset", v1, 8'h7f);
    halt_opt <= 1'b1;
    cpu_model_inst.halt(8'hff);
    wait_req(4);
    check("halt reset", reset_req, 1'b1);
    halt_opt <= 1'b0;
    hw_opt <= 1'b1;
    do_reset();
    cpu_model_inst.wr(8'h2a, 8'h3f);
    #1 check("hardware option reset", reset_req, 1'b1);
    hw_opt <= 1'b0;
    irq_en <= 1'b1;
    long_start <= 1'b1;
    do_reset();
    cpu_model_inst.halt(8'hff);
    repeat (2) @(posedge clk);
    #1 check("active halt", halted, 1'b1);
    cpu_model_inst.rd(8'h2a, v1);
    repeat (16400) @(posedge clk);
    cpu_model_inst.rd(8'h2a, v2);
    check("count frozen", v2, v1);
    check("no halt reset", reset_req, 1'b0);
    cpu_model_inst.wake();
    repeat (2) @(posedge clk);
    #1 check("woken", halted, 1'b0);
    cpu_model_inst.halt(8'hff);
    cpu_model_inst.wr(8'h2a, 8'h80);
    #1 check("reset in active halt", reset_req, 1'b1);
    repeat (4) @(posedge clk);
    cpu_model_inst.rd(8'h2a, v1);
    check("startup count", v1, 8'h80);
    repeat (1000) @(posedge clk);
    cpu_model_inst.rd(8'h2a, v2);
    check("startup frozen", v2, v1);
    irq_en <= 1'b0;
    long_start <= 1'b0;
    do_reset();
    cpu_model_inst.halt(8'hff);
    repeat (2) @(posedge clk);
    #1 check("halt entered", halted, 1'b1);
    repeat (16400) @(posedge clk);
    cpu_model_inst.rd(8'h2a, v1);
    check("one halt step", v1, 8'hfe);
    check("no reset in halt", reset_req, 1'b0);
    @(posedge clk);
    ext_wake <= 1'b1;
    @(posedge clk);
    ext_wake <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check("halt woken", halted, 1'b0);
    give_verdict();
  end
endmodule // tb_halt_aware_watchdog
